// ===== core/ipps_top.sv
// Top of the programming port: pin sharing, pin control registers, security and protection.
// What this block does
// RULE1: Nineteen pins over three ports, each set alone to software or logic use.
// RULE2: Software sets output level and reads input of each software-driven pin.
// RULE3: Pin function is fixed by stored setup; runtime level comes from software.
// RULE4: Port C link pins may be shared, acting as plain pins outside programming.
// RULE5: Programming uses four wires; the controller drives select, clock, data in.
// RULE6: The serial port programs all or part of the device without the host.
// RULE7: No boundary scan; the port stays in bypass while others scan.
// RULE8: Optional status and error lines on Port C shorten programming.
// RULE9: A set security bit denies outside access to flash and logic setup.
// RULE10: Only a full erase clears the security bit, leaving a blank device. Here a reset clears it too.
// RULE11: Each flash sector has write protect blocking host writes to it.
// RULE12: Port C: select 0, clock 1, status 3, error 4, data in 5, data out 6.
// RULE13: Active-low reset returns pins, page and setup registers to reset state.
// RULE14: Shared pins in link use ignore software output requests.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module ipps_top #(
  parameter int NUM_PINS = ipps_pkg::NUM_PINS,
  parameter int NUM_SECTORS = ipps_pkg::NUM_SECTORS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tck,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] logic_out,
  input wire logic [NUM_PINS-1:0] logic_oe,
  output logic [NUM_PINS-1:0] logic_in,
  output logic flash_wr_ok,
  output logic flash_wr_blocked
);
  ipps_link_if lnk ();

  logic [NUM_PINS-1:0] func_sel;
  logic [NUM_PINS-1:0] data_out;
  logic [NUM_PINS-1:0] dir;
  logic [NUM_PINS-1:0] in_s1;
  logic [NUM_PINS-1:0] in_s2;
  logic share_en;
  logic stat_en;
  logic secure;
  logic [NUM_SECTORS-1:0] protect;
  logic [1:0] act_sync;
  logic [1:0] blk_sync;
  logic [2:0] era_sync;
  logic erased;
  logic wr_ok_q;
  logic wr_blk_q;

  // Inputs from pins pass two flops before use; the link pins go straight
  // to the link-clock domain, which samples them on its own clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1 <= '0;
      in_s2 <= '0;
      act_sync <= 2'h0;
      blk_sync <= 2'h0;
      era_sync <= 3'h0;
    end else begin
      in_s1 <= pin_in;
      in_s2 <= in_s1;
      act_sync <= {act_sync[0], lnk.active_lvl};
      blk_sync <= {blk_sync[0], lnk.blocked_lvl};
      era_sync <= {era_sync[1:0], lnk.erase_tgl};
    end
  end

  wire erase_pulse = era_sync[2] ^ era_sync[1];
  wire isp_active = act_sync[1];

  // Link pins are claimed when sharing is off, or while programming runs. [RULE4]
  wire link_owned = !share_en || isp_active;
  assign lnk.tms = pin_in[ipps_pkg::PIN_TMS]; // [RULE12]
  assign lnk.tdi = pin_in[ipps_pkg::PIN_TDI]; // [RULE12]
  assign lnk.secure_lvl = secure;

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_func = (paddr == ipps_pkg::OFF_FUNC_SEL);
  wire hit_dout = (paddr == ipps_pkg::OFF_DATA_OUT);
  wire hit_dir = (paddr == ipps_pkg::OFF_DIR);
  wire hit_din = (paddr == ipps_pkg::OFF_DATA_IN);
  wire hit_ctl = (paddr == ipps_pkg::OFF_CONTROL);
  wire hit_st = (paddr == ipps_pkg::OFF_STATUS);
  wire hit_prot = (paddr == ipps_pkg::OFF_PROTECT);
  wire hit_fw = (paddr == ipps_pkg::OFF_FLASH_WR);
  wire mapped = hit_func || hit_dout || hit_dir || hit_din || hit_ctl || hit_st ||
    hit_prot || hit_fw;
  wire [NUM_SECTORS-1:0] fw_sector = pwdata[NUM_SECTORS-1:0];
  wire fw_hits_protected = |(fw_sector & protect); // [RULE11]

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // Setup registers: the function map is the stored static setup. [RULE3] [RULE13]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_sel <= ipps_pkg::RST_FUNC_SEL;
      data_out <= ipps_pkg::RST_DATA_OUT;
      dir <= ipps_pkg::RST_DIR;
      {secure, stat_en, share_en} <= ipps_pkg::RST_CONTROL;
      protect <= ipps_pkg::RST_PROTECT;
    end else begin
      if (wr && hit_func)
        func_sel <= pwdata[NUM_PINS-1:0]; // [RULE1]
      if (wr && hit_dout)
        data_out <= pwdata[NUM_PINS-1:0]; // [RULE2]
      if (wr && hit_dir)
        dir <= pwdata[NUM_PINS-1:0];
      if (wr && hit_ctl) begin
        share_en <= pwdata[ipps_pkg::CTL_SHARE_BIT];
        stat_en <= pwdata[ipps_pkg::CTL_STATLINES_BIT];
      end
      if (wr && hit_prot)
        protect <= pwdata[NUM_SECTORS-1:0]; // [RULE11]
      // Security can be set by software, but only a full erase or a reset clears it. [RULE10]
      if (erase_pulse)
        secure <= 1'b0; // [RULE10]
      else if (wr && hit_ctl && pwdata[ipps_pkg::CTL_SECURE_BIT])
        secure <= 1'b1; // [RULE9]
    end
  end

  // Erase marker, held until software sets security again, and host flash write gating as one-cycle pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erased <= 1'b0;
      wr_ok_q <= 1'b0;
      wr_blk_q <= 1'b0;
    end else begin
      if (erase_pulse)
        erased <= 1'b1;
      else if (wr && hit_ctl && pwdata[ipps_pkg::CTL_SECURE_BIT])
        erased <= 1'b0;
      wr_ok_q <= wr && hit_fw && !fw_hits_protected; // [RULE11]
      wr_blk_q <= wr && hit_fw && fw_hits_protected; // [RULE11]
    end
  end
  assign flash_wr_ok = wr_ok_q;
  assign flash_wr_blocked = wr_blk_q;

  // Per-pin muxing between software, logic and the programming link.
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      localparam bit IS_TDO = (g == ipps_pkg::PIN_TDO);
      localparam bit IS_STAT = (g == ipps_pkg::PIN_STAT) || (g == ipps_pkg::PIN_ERR);
      localparam bit IS_LINK_IN = (g == ipps_pkg::PIN_TMS) || (g == ipps_pkg::PIN_TCK) ||
        (g == ipps_pkg::PIN_TDI);
      wire sw_out = func_sel[g] ? logic_out[g] : data_out[g]; // [RULE1]
      wire sw_oe = func_sel[g] ? logic_oe[g] : dir[g];
      wire link_pin = (IS_TDO || IS_LINK_IN) || (IS_STAT && stat_en); // [RULE8]
      wire claimed = link_pin && link_owned; // [RULE14]
      wire link_out;
      wire link_oe;
      if (IS_TDO) begin : g_tdo
        assign link_out = lnk.tdo; // [RULE5]
        assign link_oe = lnk.tdo_oe;
      end else if (g == ipps_pkg::PIN_STAT) begin : g_stat
        assign link_out = lnk.busy; // [RULE8]
        assign link_oe = 1'b1;
      end else if (g == ipps_pkg::PIN_ERR) begin : g_err
        assign link_out = lnk.err; // [RULE8]
        assign link_oe = 1'b1;
      end else begin : g_none
        assign link_out = 1'b0;
        assign link_oe = 1'b0;
      end
      assign pin_out[g] = claimed ? link_out : sw_out; // [RULE14]
      assign pin_oe[g] = claimed ? link_oe : sw_oe; // [RULE4]
      assign logic_in[g] = in_s2[g];
    end
  endgenerate

  // Read data register.
  wire [31:0] st_word = {28'h0000000, erased, blk_sync[1], secure, isp_active};
  wire [31:0] rd_mux =
    hit_func ? {13'h0000, func_sel} :
    hit_dout ? {13'h0000, data_out} :
    hit_dir ? {13'h0000, dir} :
    hit_din ? {13'h0000, in_s2} : // [RULE2]
    hit_ctl ? {29'h00000000, secure, stat_en, share_en} :
    hit_st ? st_word :
    hit_prot ? {20'h00000, protect} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  ipps_tap u_tap (
    .tck(tck),
    .presetn(presetn),
    .lnk(lnk.link)
  );
endmodule // ipps_top

// ===== core/ipps_pkg.sv
// Package with register map, field positions and constants of the programming port block.
package ipps_pkg;
  localparam int NUM_PINS = 19;
  localparam int ADDR_W = 8;
  // Register byte offsets on the register bus.
  localparam logic [7:0] OFF_FUNC_SEL = 8'h00;
  localparam logic [7:0] OFF_DATA_OUT = 8'h04;
  localparam logic [7:0] OFF_DIR = 8'h08;
  localparam logic [7:0] OFF_DATA_IN = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PROTECT = 8'h18;
  localparam logic [7:0] OFF_FLASH_WR = 8'h1c;
  // Pin index of Port C bit 0 within the 19 pins (Port B 0..7, Port C 8..15, Port D 16..18).
  localparam int PORTC_BASE = 8;
  localparam int PIN_TMS = PORTC_BASE + 0;
  localparam int PIN_TCK = PORTC_BASE + 1;
  localparam int PIN_STAT = PORTC_BASE + 3;
  localparam int PIN_ERR = PORTC_BASE + 4;
  localparam int PIN_TDI = PORTC_BASE + 5;
  localparam int PIN_TDO = PORTC_BASE + 6;
  // Control register fields.
  localparam int CTL_SHARE_BIT = 0;
  localparam int CTL_STATLINES_BIT = 1;
  localparam int CTL_SECURE_BIT = 2;
  // Status register fields.
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_SECURE_BIT = 1;
  localparam int ST_BLOCKED_BIT = 2;
  localparam int ST_ERASED_BIT = 3;
  // Reset values.
  localparam logic [18:0] RST_FUNC_SEL = 19'h00000;
  localparam logic [18:0] RST_DATA_OUT = 19'h00000;
  localparam logic [18:0] RST_DIR = 19'h00000;
  localparam logic [2:0] RST_CONTROL = 3'h0;
  localparam logic [11:0] RST_PROTECT = 12'h000;
  localparam int NUM_SECTORS = 12;
  // Link instructions, 4 bit instruction register.
  localparam int IR_W = 4;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_ERASE_ALL = 4'h1;
  localparam logic [3:0] IR_PROG = 4'h2;
  localparam logic [3:0] IR_READ = 4'h3;
  localparam logic [3:0] IR_PROG_FLASH = 4'h4;
  localparam logic [1:0] STAT_OK = 2'h0;
  // One-hot states of the link controller.
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PA_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UP_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PA_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UP_IR = 16'h8000
  } ipps_tap_t;
endpackage

// ===== core/ipps_link_if.sv
// Interface carrying the link-side signals between the top and the link controller.
`timescale 1ns/1ps
interface ipps_link_if;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic active_tgl;
  logic active_lvl;
  logic erase_tgl;
  logic blocked_lvl;
  logic secure_lvl;
  logic busy;
  logic err;
  modport link (input tms, input tdi, input secure_lvl, output tdo, output tdo_oe,
    output active_lvl, output erase_tgl, output blocked_lvl, output busy, output err,
    output active_tgl);
  modport core (output tms, output tdi, output secure_lvl, input tdo, input tdo_oe,
    input active_lvl, input erase_tgl, input blocked_lvl, input busy, input err,
    input active_tgl);
endinterface

// ===== core/ipps_tap.sv
// Link-clock controller: test access state machine, bypass and programming instructions.
`timescale 1ns/1ps
module ipps_tap (
  input wire logic tck,
  input wire logic presetn,
  ipps_link_if.link lnk
);
  ipps_pkg::ipps_tap_t state;
  ipps_pkg::ipps_tap_t next_state;
  logic [ipps_pkg::IR_W-1:0] ir;
  logic [ipps_pkg::IR_W-1:0] ir_sh;
  logic [7:0] dr;
  logic bypass_bit;
  logic [1:0] sec_sync;
  logic erase_t;
  logic blocked;
  logic tdo_q;
  logic oe_q;
  logic busy_q;
  wire is_bypass = (ir == ipps_pkg::IR_BYPASS);
  wire protected_op = (ir == ipps_pkg::IR_PROG) || (ir == ipps_pkg::IR_READ) ||
    (ir == ipps_pkg::IR_PROG_FLASH);
  wire deny = protected_op && sec_sync[1];
  wire in_prog = (ir != ipps_pkg::IR_BYPASS) && (state != ipps_pkg::TAP_RESET);

  always_comb begin
    case (state)
      ipps_pkg::TAP_RESET: next_state = lnk.tms ? ipps_pkg::TAP_RESET : ipps_pkg::TAP_IDLE;
      ipps_pkg::TAP_IDLE: next_state = lnk.tms ? ipps_pkg::TAP_SEL_DR : ipps_pkg::TAP_IDLE;
      ipps_pkg::TAP_SEL_DR: next_state = lnk.tms ? ipps_pkg::TAP_SEL_IR : ipps_pkg::TAP_CAP_DR;
      ipps_pkg::TAP_CAP_DR: next_state = lnk.tms ? ipps_pkg::TAP_EX1_DR : ipps_pkg::TAP_SH_DR;
      ipps_pkg::TAP_SH_DR: next_state = lnk.tms ? ipps_pkg::TAP_EX1_DR : ipps_pkg::TAP_SH_DR;
      ipps_pkg::TAP_EX1_DR: next_state = lnk.tms ? ipps_pkg::TAP_UP_DR : ipps_pkg::TAP_PA_DR;
      ipps_pkg::TAP_PA_DR: next_state = lnk.tms ? ipps_pkg::TAP_EX2_DR : ipps_pkg::TAP_PA_DR;
      ipps_pkg::TAP_EX2_DR: next_state = lnk.tms ? ipps_pkg::TAP_UP_DR : ipps_pkg::TAP_SH_DR;
      ipps_pkg::TAP_UP_DR: next_state = lnk.tms ? ipps_pkg::TAP_SEL_DR : ipps_pkg::TAP_IDLE;
      ipps_pkg::TAP_SEL_IR: next_state = lnk.tms ? ipps_pkg::TAP_RESET : ipps_pkg::TAP_CAP_IR;
      ipps_pkg::TAP_CAP_IR: next_state = lnk.tms ? ipps_pkg::TAP_EX1_IR : ipps_pkg::TAP_SH_IR;
      ipps_pkg::TAP_SH_IR: next_state = lnk.tms ? ipps_pkg::TAP_EX1_IR : ipps_pkg::TAP_SH_IR;
      ipps_pkg::TAP_EX1_IR: next_state = lnk.tms ? ipps_pkg::TAP_UP_IR : ipps_pkg::TAP_PA_IR;
      ipps_pkg::TAP_PA_IR: next_state = lnk.tms ? ipps_pkg::TAP_EX2_IR : ipps_pkg::TAP_PA_IR;
      ipps_pkg::TAP_EX2_IR: next_state = lnk.tms ? ipps_pkg::TAP_UP_IR : ipps_pkg::TAP_SH_IR;
      ipps_pkg::TAP_UP_IR: next_state = lnk.tms ? ipps_pkg::TAP_SEL_DR : ipps_pkg::TAP_IDLE;
      default: next_state = ipps_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge tck or negedge presetn) begin
    if (!presetn) begin
      state <= ipps_pkg::TAP_RESET;
      sec_sync <= 2'h0;
    end else begin
      state <= next_state;
      sec_sync <= {sec_sync[0], lnk.secure_lvl};
    end
  end

  // Instruction register defaults to bypass so a shared chain sees one bit here. [RULE7]
  always_ff @(posedge tck or negedge presetn) begin
    if (!presetn) begin
      ir <= ipps_pkg::IR_BYPASS;
      ir_sh <= ipps_pkg::IR_BYPASS;
    end else if (state == ipps_pkg::TAP_RESET) begin
      ir <= ipps_pkg::IR_BYPASS; // [RULE7]
    end else if (state == ipps_pkg::TAP_CAP_IR) begin
      ir_sh <= 4'h1;
    end else if (state == ipps_pkg::TAP_SH_IR) begin
      ir_sh <= {lnk.tdi, ir_sh[ipps_pkg::IR_W-1:1]};
    end else if (state == ipps_pkg::TAP_UP_IR) begin
      ir <= ir_sh;
    end
  end

  // Data path: bypass bit, or an 8-bit programming register whose read is
  // replaced by zeros while the content is locked. [RULE9]
  always_ff @(posedge tck or negedge presetn) begin
    if (!presetn) begin
      dr <= 8'h00;
      bypass_bit <= 1'b0;
      blocked <= 1'b0;
      erase_t <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      if (state == ipps_pkg::TAP_CAP_DR) begin
        bypass_bit <= 1'b0;
        dr <= deny ? 8'h00 : {6'h00, ipps_pkg::STAT_OK}; // [RULE9]
      end else if (state == ipps_pkg::TAP_SH_DR) begin
        bypass_bit <= lnk.tdi;
        dr <= {lnk.tdi, dr[7:1]};
      end
      if (state == ipps_pkg::TAP_UP_DR) begin
        blocked <= deny; // [RULE9]
        busy_q <= protected_op && !deny; // [RULE6]
        if (ir == ipps_pkg::IR_ERASE_ALL)
          erase_t <= ~erase_t; // [RULE10]
      end else if (state == ipps_pkg::TAP_IDLE) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Output changes on the falling edge of the link clock, as the link expects. [RULE5]
  always_ff @(negedge tck or negedge presetn) begin
    if (!presetn) begin
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= (state == ipps_pkg::TAP_SH_DR) || (state == ipps_pkg::TAP_SH_IR);
      if (state == ipps_pkg::TAP_SH_IR)
        tdo_q <= ir_sh[0];
      else
        tdo_q <= is_bypass ? bypass_bit : dr[0];
    end
  end

  assign lnk.tdo = tdo_q;
  assign lnk.tdo_oe = oe_q;
  assign lnk.active_lvl = in_prog;
  assign lnk.active_tgl = 1'b0;
  assign lnk.erase_tgl = erase_t;
  assign lnk.blocked_lvl = blocked;
  assign lnk.busy = busy_q;
  assign lnk.err = blocked;
endmodule // ipps_tap

// ===== test/ipps_top_asserts.sv
// Checker of the programming port top: bus map, flash write pulses and pin control.
`timescale 1ns/1ps
module ipps_top_asserts #(
  parameter int NUM_PINS = ipps_pkg::NUM_PINS,
  parameter int NUM_SECTORS = ipps_pkg::NUM_SECTORS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] logic_out,
  input wire logic [NUM_PINS-1:0] logic_oe,
  input wire logic [NUM_PINS-1:0] logic_in,
  input wire logic flash_wr_ok,
  input wire logic flash_wr_blocked
);
  // Shadow copies of the written registers, so outputs can be tied to their cause.
  logic [NUM_PINS-1:0] fsel, dout, dir;
  logic [NUM_SECTORS-1:0] prot;
  logic share;
  wire acc = psel && penable && pready;
  wire wr = acc && pwrite;
  wire mapped = paddr[1:0] == 2'h0 && paddr <= ipps_pkg::OFF_FLASH_WR;
  wire hit = |(pwdata[NUM_SECTORS-1:0] & prot);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel <= '0;
      dout <= '0;
      dir <= '0;
      prot <= '0;
      share <= 1'b0;
    end else if (wr) begin
      case (paddr)
        ipps_pkg::OFF_FUNC_SEL: fsel <= pwdata[NUM_PINS-1:0];
        ipps_pkg::OFF_DATA_OUT: dout <= pwdata[NUM_PINS-1:0];
        ipps_pkg::OFF_DIR: dir <= pwdata[NUM_PINS-1:0];
        ipps_pkg::OFF_PROTECT: prot <= pwdata[NUM_SECTORS-1:0];
        ipps_pkg::OFF_CONTROL: share <= pwdata[ipps_pkg::CTL_SHARE_BIT];
        default: ;
      endcase
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fw_req;
    wr && paddr == ipps_pkg::OFF_FLASH_WR;
  endsequence
  sequence rd_fsel;
    acc && !pwrite && paddr == ipps_pkg::OFF_FUNC_SEL;
  endsequence
  pready_on_a: assert property (pready) else $error("pready low");
  slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response does not match address map");
  fw_blocked_a: assert property (fw_req ##0 hit |=> flash_wr_blocked && !flash_wr_ok)
    else $error("protected sector write not blocked");
  fw_passed_a: assert property (fw_req ##0 !hit |=> flash_wr_ok && !flash_wr_blocked)
    else $error("unprotected sector write not accepted");
  fw_cause_a: assert property (flash_wr_ok || flash_wr_blocked |-> $past(wr && paddr == 8'h1c))
    else $error("flash pulse without a write");
  sw_pin_a: assert property (!fsel[0] |-> pin_out[0] == dout[0] && pin_oe[0] == dir[0])
    else $error("software pin not following its registers");
  pld_pin_a: assert property (fsel[NUM_PINS-1] |-> pin_out[NUM_PINS-1] == logic_out[NUM_PINS-1]
    && pin_oe[NUM_PINS-1] == logic_oe[NUM_PINS-1]) else $error("logic pin not following logic");
  in_sync_a: assert property ($past(presetn, 2) |-> logic_in == $past(pin_in, 2))
    else $error("logic input not two cycles behind pins");
  rd_fsel_a: assert property (rd_fsel |-> prdata[NUM_PINS-1:0] == fsel)
    else $error("function select read back wrong");
  link_own_a: assert property (!share |-> !pin_oe[ipps_pkg::PIN_TMS] && !pin_oe[ipps_pkg::PIN_TDI])
    else $error("link input pin driven by the device");
endmodule // ipps_top_asserts
bind ipps_top ipps_top_asserts #(.NUM_PINS(NUM_PINS), .NUM_SECTORS(NUM_SECTORS)) chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe,
  .logic_out, .logic_oe, .logic_in, .flash_wr_ok, .flash_wr_blocked);

// ===== test/ipps_jtag_model.sv
// Programming controller model: drives the four-wire link, clock only within frames.
`timescale 1ns/1ps
module ipps_jtag_model (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic sampled;
  logic [7:0] got;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One 32 ns link clock; select and data change after the falling edge.
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #16;
    // Data out is taken just before the rising edge, where the device holds it still.
    sampled = tdo;
    tck = 1'b1;
    #16 tck = 1'b0;
  endtask
  // Each frame starts an odd nanosecond after a system clock edge, so no link edge
  // ever lands in the same time step as a rising system clock edge.
  task automatic tap_reset();
    #1;
    repeat (5) step(1'b1, tdi);
    step(1'b0, tdi);
  endtask
  // Shifts n bits, lowest first, into the instruction or data path, ending in idle.
  task automatic shift(input logic ir, input logic [7:0] v, input int n);
    #1;
    step(1'b1, tdi);
    if (ir) step(1'b1, tdi);
    step(1'b0, tdi);
    step(1'b0, tdi);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i]);
      got[i] = sampled;
    end
    step(1'b1, tdi);
    step(1'b0, tdi);
    // A released data line must not keep showing the last bit.
    tdi = ~tdi;
  endtask
endmodule // ipps_jtag_model

// ===== test/testbench.sv
// Self-checking bench of the programming port top with a link controller model.
`timescale 1ns/1ps
module testbench;
  typedef struct {string name; logic [31:0] exp; logic [31:0] mask; logic err;} ipps_note_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tck, tms, tdi;
  logic flash_wr_ok, flash_wr_blocked;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [18:0] pin_in, pin_out, pin_oe, logic_out, logic_oe, logic_in, pin_ext, r;
  int fails, checked;
  ipps_note_t notes[$], n;
  localparam logic [18:0] NOTC = 19'h700ff;
  localparam logic [7:0] OFFS [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18};
  localparam logic [3:0] CODES [4] = '{4'h2, 4'h3, 4'h4, 4'hf};
  ipps_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tck, .pin_in, .pin_out, .pin_oe, .logic_out, .logic_oe, .logic_in, .flash_wr_ok,
    .flash_wr_blocked);
  ipps_jtag_model jt (.tck, .tms, .tdi, .tdo(pin_out[ipps_pkg::PIN_TDO]));
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & pin_ext);
    pin_in[ipps_pkg::PIN_TMS] = tms;
    pin_in[ipps_pkg::PIN_TCK] = tck;
    pin_in[ipps_pkg::PIN_TDI] = tdi;
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [18:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[18:0];
  endfunction
  task automatic check(input string s, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // For a read d is the expected data; a write compares the error response only.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input string s);
    int i;
    notes.push_back('{s, d, w ? 32'h0 : m, a > 8'h1c || a[1:0] != 2'h0});
    // One idle edge between transfers, so no bus signal is assigned twice in a time step.
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      fails++;
      conclude();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic flash(input logic [31:0] d, input logic [31:0] e);
    apb(1'b1, ipps_pkg::OFF_FLASH_WR, d, 32'h0, "flash write");
    notes.push_back('{"flash pulse", e, 32'h3, 1'b0});
  endtask
  task automatic jtag(input logic [3:0] ir, input logic [7:0] v);
    logic [7:0] e;
    jt.shift(1'b1, {4'h0, ir}, ipps_pkg::IR_W);
    @(posedge pclk);
    jt.shift(1'b0, v, 8);
    // A bypassed word comes out one bit late, behind the captured zero.
    e = (ir == ipps_pkg::IR_BYPASS) ? {v[6:0], 1'b0} : 8'h00;
    check("link out", {25'h0, jt.got}, {25'h0, e});
    repeat (10) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && notes.size() > 0) begin
      n = notes.pop_front();
      check(n.name, {pslverr, prdata & n.mask}, {n.err, n.exp & n.mask});
    end else if (flash_wr_ok || flash_wr_blocked) begin
      if (notes.size() > 0) n = notes.pop_front();
      else n = '{"stray pulse", 32'h0, 32'h3, 1'b0};
      check(n.name, {31'h0, flash_wr_blocked, flash_wr_ok}, {1'b0, n.exp});
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {pin_ext, logic_out, logic_oe, fails, checked} = '0;
    seed = 32'h0000d4c1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    jt.tap_reset();
    @(posedge pclk);
    foreach (OFFS[k]) apb(1'b0, OFFS[k], 32'h0, 32'h7ffff, "reset value");
    apb(1'b0, 8'h24, 32'h0, 32'h0, "unmapped");
    r = rnd();
    apb(1'b1, ipps_pkg::OFF_DIR, 32'h7ffff, 32'h0, "dir");
    apb(1'b1, ipps_pkg::OFF_DATA_OUT, {13'h0, r}, 32'h0, "data out");
    @(posedge pclk);
    check("sw pins", {14'h0, pin_out & NOTC}, {14'h0, r & NOTC});
    check("sw enables", {14'h0, pin_oe & NOTC}, {14'h0, NOTC});
    apb(1'b1, ipps_pkg::OFF_DIR, 32'h0, 32'h0, "dir");
    pin_ext <= rnd();
    repeat (4) @(posedge pclk);
    apb(1'b0, ipps_pkg::OFF_DATA_IN, {13'h0, pin_ext}, {13'h0, NOTC}, "data in");
    logic_out <= rnd();
    logic_oe <= rnd();
    apb(1'b1, ipps_pkg::OFF_FUNC_SEL, 32'h7ffff, 32'h0, "func sel");
    apb(1'b0, ipps_pkg::OFF_FUNC_SEL, 32'h7ffff, 32'h7ffff, "func sel");
    check("pld pins", {14'h0, pin_out & NOTC}, {14'h0, logic_out & NOTC});
    check("pld inputs", {14'h0, logic_in}, {14'h0, pin_in});
    apb(1'b1, ipps_pkg::OFF_FUNC_SEL, 32'h0, 32'h0, "func sel");
    apb(1'b1, ipps_pkg::OFF_DIR, 32'h7ffff, 32'h0, "dir");
    apb(1'b1, ipps_pkg::OFF_DATA_OUT, 32'h7ffff, 32'h0, "data out");
    apb(1'b1, ipps_pkg::OFF_CONTROL, 32'h1, 32'h0, "share on");
    @(posedge pclk);
    check("shared select pin", {31'h0, pin_oe[8], pin_out[8]}, 33'h3);
    apb(1'b1, ipps_pkg::OFF_CONTROL, 32'h0, 32'h0, "share off");
    @(posedge pclk);
    check("link select pin", {32'h0, pin_oe[8]}, 33'h0);
    apb(1'b1, ipps_pkg::OFF_PROTECT, 32'h5, 32'h0, "protect");
    flash(32'h4, 32'h2);
    flash(32'ha, 32'h1);
    flash(32'h800, 32'h1);
    apb(1'b1, ipps_pkg::OFF_CONTROL, 32'h4, 32'h0, "secure on");
    apb(1'b1, ipps_pkg::OFF_CONTROL, 32'h2, 32'h0, "status lines on");
    apb(1'b0, ipps_pkg::OFF_STATUS, 32'h2, 32'h2, "secure kept");
    jtag(ipps_pkg::IR_READ, 8'ha5);
    apb(1'b0, ipps_pkg::OFF_STATUS, 32'h6, 32'h6, "read denied");
    check("status lines", {30'h0, pin_oe[11], pin_out[11], pin_out[12]}, 33'h5);
    jtag(ipps_pkg::IR_ERASE_ALL, 8'h00);
    apb(1'b0, ipps_pkg::OFF_STATUS, 32'h8, 32'ha, "erased");
    foreach (CODES[k]) begin
      jtag(CODES[k], 8'h3c);
      apb(1'b0, ipps_pkg::OFF_STATUS, {31'h0, CODES[k] != ipps_pkg::IR_BYPASS}, 32'h5,
        "op allowed");
    end
    repeat (3) @(posedge pclk);
    if (notes.size() != 0) fails++;
    conclude();
  end
endmodule // testbench
